// file: hdl/lcd_decoder.sv
// display instruction decoder: device end of the serial link
`timescale 1ns/100ps
module lcd_decoder
  import lcd_pkg::*;
(
  input  wire logic        clk,                 // system clock
  input  wire logic        rst_n,               // async reset, active low
  lcd_link_if.dev          link,                // serial link from host
  input  wire logic        key_scan_busy,       // key scan running
  input  wire logic [3:0]  scan_digit,          // digit being driven
  output logic [7:0]       glyph_code_q,        // code for scanned digit
  output logic             glyph_user_q,        // code picks user store
  output logic             dot_lit_q,           // dot pattern shown
  output logic [4:0]       side_seg_q,          // side segments shown
  output logic             lowest_bias_level_q, // hold all outputs low
  output logic             osc_run_q,           // timebase running
  output logic             ext_timebase_pick_q, // external clock mode
  output logic             low_power_select_q,  // sleep state
  output logic             auto_increment_q     // increment mode active
);
  logic [63:0] f;
  logic [6:0]  nb;
  logic        done;
  logic [3:0]  op;

  logic [15:0] digit_on_mask_q;
  logic        dot_matrix_content_q;
  logic        side_seg_content_q;
  logic        outputs_off_q;
  logic [5:0]  char_ram_addr_q;
  logic [3:0]  side_seg_store_index_q;
  logic [5:0]  char_ofs_q;
  logic [3:0]  side_ofs_q;
  logic        char_inc_q;
  logic        side_inc_q;
  logic [7:0]  char_code_store [CHAR_DEPTH];
  logic [4:0]  side_seg_store  [DIGITS];

  logic        do_char;
  logic        do_side;
  logic [7:0]  wr_code;
  logic [4:0]  wr_side;
  logic [5:0]  wr_caddr;
  logic [3:0]  wr_saddr;
  logic        next_inc;
  logic        exec_ok;

  // ---------------------------------------------------------------------------
  // frame capture
  // ---------------------------------------------------------------------------
  serial_capture u_cap (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (link.ce),
    .sclk    (link.shift_strobe),
    .sdi     (link.serial_in),
    .frame_q (f),
    .nbits_q (nb),
    .done_q  (done)
  );

  assign op = frame_op(f);

  // ---------------------------------------------------------------------------
  // write decode: normal and increment-mode frame forms
  // ---------------------------------------------------------------------------
  always_comb begin
    do_char  = 1'b0;
    do_side  = 1'b0;
    wr_code  = f[CODE_LSB +: 8];
    wr_side  = f[CODE_LSB +: SIDE_BITS];
    wr_caddr = f[CADDR_LSB +: 6];
    wr_saddr = f[SW_ADDR_LSB +: 4];
    next_inc = f[INC_BIT];
    if (char_inc_q) begin
      wr_caddr = char_ram_addr_q;
      if (nb == LEN_SHORT) begin
        do_char  = 1'b1;
        wr_code  = f[SHORT_LSB +: 8];
        next_inc = 1'b1;
      end else if (nb == LEN_MID && op == OP_CHARWR && !f[INC_BIT]) begin
        do_char  = 1'b1;
        wr_code  = f[MID_LSB +: 8];
        next_inc = 1'b0;
      end else if (nb >= LEN_LONG && op == OP_CHARWR) begin
        do_char  = 1'b1;
        wr_caddr = f[CADDR_LSB +: 6];
      end
    end else if (side_inc_q) begin
      wr_saddr = side_seg_store_index_q;
      if (nb == LEN_SHORT) begin
        do_side  = 1'b1;
        wr_side  = f[SHORT_LSB +: SIDE_BITS];
        next_inc = 1'b1;
      end else if (nb == LEN_MID && op == OP_SIDEWR && !f[INC_BIT]) begin
        do_side  = 1'b1;
        wr_side  = f[MID_LSB +: SIDE_BITS];
        next_inc = 1'b0;
      end else if (nb >= LEN_LONG && op == OP_SIDEWR) begin
        do_side  = 1'b1;
        wr_saddr = f[SW_ADDR_LSB +: 4];
      end
    end else if (!low_power_select_q) begin
      do_char = op == OP_CHARWR;
      do_side = op == OP_SIDEWR;
    end
  end

  // plain instructions run outside increment mode; sleep admits on/off only
  assign exec_ok = done && !char_inc_q && !side_inc_q &&
                   (!low_power_select_q || op == OP_ONOFF);

  // ---------------------------------------------------------------------------
  // display on/off and timebase state
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      digit_on_mask_q      <= MASK_RESET;
      dot_matrix_content_q <= 1'b0;
      side_seg_content_q   <= 1'b0;
      outputs_off_q        <= 1'b0;
      low_power_select_q   <= 1'b0;
      ext_timebase_pick_q  <= 1'b0;
    end else if (exec_ok && op == OP_ONOFF) begin
      digit_on_mask_q      <= f[DIGIT_LSB +: DIGITS];
      dot_matrix_content_q <= f[SEL_DOT_BIT];
      side_seg_content_q   <= f[SEL_SIDE_BIT];
      outputs_off_q        <= f[BLANK_BIT];
      low_power_select_q   <= f[SLEEP_BIT];
    end else if (exec_ok && op == OP_TECH) begin
      ext_timebase_pick_q  <= f[TIMEBASE_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // display window shift
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      char_ofs_q <= 6'h00;
      side_ofs_q <= 4'h0;
    end else if (exec_ok && op == OP_SETADDR) begin
      // address load also places the window start
      char_ofs_q <= f[CADDR_LSB +: 6];
      side_ofs_q <= f[SADDR_LSB +: 4];
    end else if (exec_ok && op == OP_SHIFT) begin
      if (f[SEL_DOT_BIT]) begin
        char_ofs_q <= f[DIR_BIT] ? 6'(char_ofs_q - 6'h01) : 6'(char_ofs_q + 6'h01);
      end
      if (f[SEL_SIDE_BIT]) begin
        side_ofs_q <= f[DIR_BIT] ? 4'(side_ofs_q - 4'h1) : 4'(side_ofs_q + 4'h1);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // address pointer and increment modes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      char_ram_addr_q        <= 6'h00;
      side_seg_store_index_q <= 4'h0;
      char_inc_q             <= 1'b0;
      side_inc_q             <= 1'b0;
    end else if (exec_ok && op == OP_SETADDR) begin
      char_ram_addr_q        <= f[CADDR_LSB +: 6];
      side_seg_store_index_q <= f[SADDR_LSB +: 4];
    end else if (done && do_char) begin
      char_ram_addr_q <= next_inc ? 6'(wr_caddr + 6'h01) : wr_caddr;
      char_inc_q      <= next_inc;
    end else if (done && do_side) begin
      side_seg_store_index_q <= next_inc ? 4'(wr_saddr + 4'h1) : wr_saddr;
      side_inc_q             <= next_inc;
    end
  end

  // ---------------------------------------------------------------------------
  // display stores
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHAR_DEPTH; i++) begin
        char_code_store[i] <= 8'h00;
      end
      for (int i = 0; i < DIGITS; i++) begin
        side_seg_store[i] <= 5'h00;
      end
    end else if (done && do_char) begin
      char_code_store[wr_caddr] <= wr_code;
    end else if (done && do_side) begin
      side_seg_store[wr_saddr] <= wr_side;
    end
  end

  // ---------------------------------------------------------------------------
  // scanned digit outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      glyph_code_q        <= 8'h00;
      glyph_user_q        <= 1'b0;
      dot_lit_q           <= 1'b0;
      side_seg_q          <= 5'h00;
      lowest_bias_level_q <= 1'b0;
      osc_run_q           <= 1'b1;
      auto_increment_q    <= 1'b0;
    end else begin
      glyph_code_q <= char_code_store[6'(char_ofs_q + {2'h0, scan_digit})];
      glyph_user_q <= char_code_store[6'(char_ofs_q + {2'h0, scan_digit})]
                      < 8'(USER_GLYPHS);
      dot_lit_q    <= dot_matrix_content_q && digit_on_mask_q[scan_digit] &&
                      !outputs_off_q && !low_power_select_q;
      side_seg_q   <= (side_seg_content_q && digit_on_mask_q[scan_digit] &&
                       !outputs_off_q && !low_power_select_q)
                      ? side_seg_store[4'(side_ofs_q + scan_digit)] : 5'h00;
      lowest_bias_level_q <= outputs_off_q || low_power_select_q;
      osc_run_q           <= !low_power_select_q || key_scan_busy;
      auto_increment_q    <= char_inc_q || side_inc_q;
    end
  end
endmodule

// file: hdl/lcd_host.sv
// host end: sends addressed frames over the serial link
`timescale 1ns/100ps
module lcd_host
  import lcd_pkg::*;
(
  input  wire logic        clk,       // system clock
  input  wire logic        rst_n,     // async reset, active low
  input  wire logic        req,       // send one frame
  input  wire logic [63:0] req_frame, // frame, D63 at bit 63
  input  wire logic [6:0]  req_bits,  // bits to send, 1..64
  output logic             busy_q,    // transfer or spacing in progress
  lcd_link_if.host         link       // serial link to decoder
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_ADDR = 4'b0010,
    S_DATA = 4'b0100,
    S_GAP  = 4'b1000
  } host_state_t;

  host_state_t state_q;
  logic [2:0]  phase_q;
  logic [6:0]  left_q;
  logic [63:0] sh_q;
  logic [11:0] gap_q;
  logic        ce_q;
  logic        cl_q;
  logic        di_q;

  assign link.ce           = ce_q;
  assign link.shift_strobe = cl_q;
  assign link.serial_in    = di_q;

  // ---------------------------------------------------------------------------
  // frame sequencer; link clock is clk divided by eight
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      phase_q <= 3'h0;
      left_q  <= 7'h00;
      sh_q    <= 64'h0;
      gap_q   <= 12'h000;
      ce_q    <= 1'b0;
      cl_q    <= 1'b0;
      di_q    <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (req && req_bits != 7'h00 && req_bits <= LEN_FULL) begin
            state_q <= S_ADDR;
            sh_q    <= {56'h0, DEV_ADDR};
            left_q  <= 7'h08;
            phase_q <= 3'h0;
            busy_q  <= 1'b1;
          end
        end
        S_ADDR, S_DATA: begin
          phase_q <= 3'(phase_q + 3'h1);
          if (phase_q == PH_DATA) begin
            di_q <= sh_q[0];
          end else if (phase_q == PH_RISE) begin
            cl_q <= 1'b1;
          end else if (phase_q == PH_FALL) begin
            cl_q <= 1'b0;
          end else if (phase_q == PH_LAST) begin
            sh_q   <= {1'b0, sh_q[63:1]};
            left_q <= 7'(left_q - 7'h01);
            if (left_q == 7'h01 && state_q == S_ADDR) begin
              state_q <= S_DATA;
              ce_q    <= 1'b1;
              sh_q    <= req_frame >> (7'(LEN_FULL - req_bits));
              left_q  <= req_bits;
            end else if (left_q == 7'h01) begin
              state_q <= S_GAP;
              ce_q    <= 1'b0;
              gap_q   <= 12'(GAP_CYCLES);
            end
          end
        end
        S_GAP: begin
          gap_q <= 12'(gap_q - 12'h001);
          if (gap_q == 12'h001) begin
            state_q <= S_IDLE;
            busy_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// file: hdl/serial_capture.sv
// synchronises the serial link and assembles frames
`timescale 1ns/100ps
module serial_capture
  import lcd_pkg::*;
(
  input  wire logic        clk,      // system clock
  input  wire logic        rst_n,    // async reset, active low
  input  wire logic        ce,       // link enable pin
  input  wire logic        sclk,     // link clock pin
  input  wire logic        sdi,      // link data pin
  output logic [63:0]      frame_q,  // assembled frame, last bit at 63
  output logic [6:0]       nbits_q,  // bits received
  output logic             done_q    // one-cycle frame latch pulse
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [1:0] prev_q;
  logic [7:0] addr_q;
  logic       ce_now;
  logic       cl_rise;
  logic       ce_rise;
  logic       ce_fall;

  // ---------------------------------------------------------------------------
  // two-stage synchronisers and edge detection
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= 3'h0;
      s2_q   <= 3'h0;
      prev_q <= 2'h0;
    end else begin
      s1_q   <= {ce, sclk, sdi};
      s2_q   <= s1_q;
      prev_q <= s2_q[2:1];
    end
  end

  assign ce_now  = s2_q[2];
  assign cl_rise = s2_q[1] & ~prev_q[0];
  assign ce_rise = ce_now & ~prev_q[1];
  assign ce_fall = ~ce_now & prev_q[1];

  // ---------------------------------------------------------------------------
  // address byte while enable low, data while enable high
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q  <= 8'h00;
      frame_q <= 64'h0;
      nbits_q <= 7'h00;
    end else if (ce_rise) begin
      frame_q <= 64'h0;
      nbits_q <= 7'h00;
    end else if (cl_rise && !ce_now) begin
      addr_q <= {s2_q[0], addr_q[7:1]};
    end else if (cl_rise && nbits_q != LEN_FULL) begin
      frame_q <= {s2_q[0], frame_q[63:1]};
      nbits_q <= 7'(nbits_q + 7'h01);
    end
  end

  // latch only frames addressed to this decoder
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= ce_fall && addr_q == DEV_ADDR && nbits_q != 7'h00;
    end
  end
endmodule

// file: include/lcd_link_if.sv
// three-wire serial link between host and display decoder
`timescale 1ns/100ps
interface lcd_link_if;
  logic ce;          // frame enable
  logic shift_strobe; // serial clock
  logic serial_in;   // serial data
  modport dev  (input ce, input shift_strobe, input serial_in);
  modport host (output ce, output shift_strobe, output serial_in);
endinterface

// file: include/lcd_pkg.sv
// constants and helpers shared by both ends of the display instruction link
// ----------------------------------------------------------------------------
// Overview of operation
// - timebase pick bit: 0 internal RC, 1 external
// - on/off frame: digit mask, selects, blank, sleep
// - both selects clear forces display off entirely
// - each digit mask bit lights its digit
// - blank bit holds all outputs at lowest bias
// - sleep holds outputs low, stops timebase unless scanning
// - in sleep only on/off instruction is executed
// - host keeps external clock through execution time; lcd_host drives no external clock
// - shift frame moves dot, side, both, or none
// - direction bit: 0 shifts left, 1 right
// - set address loads char and side pointers
// - char write stores code at supplied address
// - stored code selects glyph rom or user store
// - increment bit advances char address after write
// - during char increment only char writes accepted
// - increment mode uses 24, 8 and 16 bit frames
// - side write stores five bits at supplied address
// - side bit n lights segment 5m+n directly
// - bits sampled on clock rise, latched on enable fall
// - side increment bit advances side address
// - host spaces frames beyond execution time
// ----------------------------------------------------------------------------
package lcd_pkg;
  // ---------------------------------------------------------------------------
  // link framing
  // ---------------------------------------------------------------------------
  localparam logic [7:0] DEV_ADDR    = 8'h42;
  localparam int         FRAME_BITS  = 64;
  localparam logic [6:0] LEN_SHORT   = 7'h08;
  localparam logic [6:0] LEN_MID     = 7'h10;
  localparam logic [6:0] LEN_LONG    = 7'h18;
  localparam logic [6:0] LEN_FULL    = 7'h40;
  // ---------------------------------------------------------------------------
  // opcodes, read as D60 D61 D62 D63
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OP_TECH     = 4'h1;
  localparam logic [3:0] OP_ONOFF    = 4'h2;
  localparam logic [3:0] OP_SHIFT    = 4'h3;
  localparam logic [3:0] OP_SETADDR  = 4'h4;
  localparam logic [3:0] OP_CHARWR   = 4'h5;
  localparam logic [3:0] OP_SIDEWR   = 4'h6;
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int OP_POS       = 60;
  localparam int DIGIT_LSB    = 40;
  localparam int SEL_DOT_BIT  = 56;
  localparam int SEL_SIDE_BIT = 57;
  localparam int BLANK_BIT    = 58;
  localparam int DIR_BIT      = 58;
  localparam int SLEEP_BIT    = 59;
  localparam int TIMEBASE_BIT = 59;
  localparam int CODE_LSB     = 40;
  localparam int CADDR_LSB    = 48;
  localparam int SADDR_LSB    = 56;
  localparam int SW_ADDR_LSB  = 48;
  localparam int INC_BIT      = 56;
  localparam int SHORT_LSB    = 56;
  localparam int MID_LSB      = 48;
  // ---------------------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------------------
  localparam int          DIGITS       = 16;
  localparam int          CHAR_DEPTH   = 64;
  localparam int          SIDE_BITS    = 5;
  localparam int          USER_GLYPHS  = 16;
  localparam logic [15:0] MASK_RESET   = 16'h0000;
  // ---------------------------------------------------------------------------
  // timing: 27 us execution at 300 kHz, 10 ns system clock
  // ---------------------------------------------------------------------------
  localparam int EXEC_TIME_NS   = 27000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int EXEC_CYCLES    = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_MARGIN     = 300;
  localparam int GAP_CYCLES     = EXEC_CYCLES + GAP_MARGIN;
  localparam int LINK_HALF      = 4;
  localparam logic [2:0] PH_DATA  = 3'h0;
  localparam logic [2:0] PH_RISE  = 3'h2;
  localparam logic [2:0] PH_FALL  = 3'h6;
  localparam logic [2:0] PH_LAST  = 3'h7;

  // opcode of a latched frame
  function automatic logic [3:0] frame_op(input logic [63:0] f);
    frame_op = {f[OP_POS], f[OP_POS+1], f[OP_POS+2], f[OP_POS+3]};
  endfunction
endpackage

// file: testbench/lcd_display_instruction_decoder_test.sv
// self-checking bench: host and decoder joined over the link
`timescale 1ns/100ps
module lcd_display_instruction_decoder_test
  import lcd_pkg::*;
;
  logic        clk, rst_n, req, busy_q, key_scan_busy;   // clock, reset, host and scan controls
  logic [63:0] req_frame;                                // frame to send
  logic [6:0]  req_bits;                                 // frame length
  logic [3:0]  scan_digit;                               // scanned digit
  logic [7:0]  glyph_code_q;                             // shown code
  logic [4:0]  side_seg_q;                               // shown side segments
  logic        glyph_user_q, dot_lit_q, lowest_bias_level_q;  // scan outputs
  logic        osc_run_q, ext_timebase_pick_q, low_power_select_q, auto_increment_q; // state
  int          num_errors, comparisons;                  // counters
  lcd_link_if link_if ();
  lcd_host i_lcd_host (.clk, .rst_n, .req, .req_frame, .req_bits, .busy_q, .link(link_if));
  lcd_decoder i_lcd_decoder (.clk, .rst_n, .link(link_if), .key_scan_busy, .scan_digit,
    .glyph_code_q, .glyph_user_q, .dot_lit_q, .side_seg_q, .lowest_bias_level_q, .osc_run_q,
    .ext_timebase_pick_q, .low_power_select_q, .auto_increment_q);
  lcd_link_props i_lcd_link_props (.clk, .rst_n, .ce(link_if.ce),
    .shift_strobe(link_if.shift_strobe), .serial_in(link_if.serial_in));
  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one frame through the host, waits until its spacing has run out
  task automatic send(input logic [63:0] f, input logic [6:0] n);
    int k;
    k = 0;
    @(posedge clk);
    req <= 1'b1;
    req_frame <= f;
    req_bits <= n;
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy_q !== 1'b0 && k < 8000) begin
      @(posedge clk);
      k++;
    end
    chk({14'h0, busy_q}, 15'h0);
  endtask
  // frame with opcode and fields D40..D59
  task automatic wr(input logic [3:0] op, input logic [15:0] lo, input logic [3:0] hi,
                    input logic [6:0] n);
    logic [63:0] f;
    f = 64'h0;
    {f[60], f[61], f[62], f[63]} = op;
    f[55:40] = lo;
    f[59:56] = hi;
    send(f, n);
  endtask
  // decoder state: bias, osc, timebase, sleep, increment
  task automatic st(input logic [4:0] e);
    chk({10'h0, lowest_bias_level_q, osc_run_q, ext_timebase_pick_q, low_power_select_q,
         auto_increment_q}, {10'h0, e});
  endtask
  // scanned outputs for one digit
  task automatic see(input logic [3:0] d, input logic [7:0] c, input logic dl,
                     input logic [4:0] sd);
    @(posedge clk);
    scan_digit <= d;
    repeat (2) @(posedge clk);
    chk({glyph_code_q, glyph_user_q, dot_lit_q, side_seg_q}, {c, c < 8'h10, dl, sd});
  endtask
  task automatic t_timebase;
    wr(OP_TECH, 16'h0, 4'h8, LEN_SHORT);
    st(5'b01100);
    wr(OP_TECH, 16'h0, 4'h0, LEN_SHORT);
    st(5'b01000);
  endtask
  task automatic t_digits;
    wr(OP_CHARWR, 16'h0541, 4'h0, LEN_LONG);
    wr(OP_CHARWR, 16'h060f, 4'h0, LEN_LONG);
    wr(OP_ONOFF, 16'h0020, 4'h1, LEN_LONG);
    see(4'h5, 8'h41, 1'b1, 5'h00);
    see(4'h6, 8'h0f, 1'b0, 5'h00);
    wr(OP_ONOFF, 16'hffff, 4'h0, LEN_LONG);
    see(4'h5, 8'h41, 1'b0, 5'h00);
  endtask
  task automatic t_side;
    wr(OP_SIDEWR, 16'h0515, 4'h0, LEN_LONG);
    wr(OP_ONOFF, 16'hffff, 4'h2, LEN_LONG);
    see(4'h5, 8'h41, 1'b0, 5'h15);
    wr(OP_ONOFF, 16'hffff, 4'h3, LEN_LONG);
    see(4'h5, 8'h41, 1'b1, 5'h15);
  endtask
  task automatic t_inc;
    wr(OP_CHARWR, 16'h0a61, 4'h1, LEN_LONG);
    st(5'b01001);
    send({8'h62, 56'h0}, LEN_SHORT);
    wr(OP_ONOFF, 16'h0000, 4'h0, LEN_LONG);
    wr(OP_CHARWR, 16'h6300, 4'h0, LEN_MID);
    st(5'b01000);
    see(4'ha, 8'h61, 1'b1, 5'h00);
    see(4'hb, 8'h62, 1'b1, 5'h00);
    see(4'hc, 8'h63, 1'b1, 5'h00);
    wr(OP_SIDEWR, 16'h0801, 4'h1, LEN_LONG);
    st(5'b01001);
    send({8'h02, 56'h0}, LEN_SHORT);
    wr(OP_SIDEWR, 16'h0400, 4'h0, LEN_MID);
    st(5'b01000);
    see(4'h8, 8'h00, 1'b1, 5'h01);
    see(4'h9, 8'h00, 1'b1, 5'h02);
    see(4'ha, 8'h61, 1'b1, 5'h04);
  endtask
  task automatic t_sleep;
    wr(OP_ONOFF, 16'hffff, 4'h7, LEN_LONG);
    st(5'b11000);
    wr(OP_ONOFF, 16'hffff, 4'hb, LEN_LONG);
    st(5'b10010);
    @(posedge clk);
    key_scan_busy <= 1'b1;
    repeat (3) @(posedge clk);
    st(5'b11010);
    key_scan_busy <= 1'b0;
    wr(OP_CHARWR, 16'h057e, 4'h0, LEN_LONG);
    wr(OP_ONOFF, 16'hffff, 4'h3, LEN_LONG);
    st(5'b01000);
    see(4'h5, 8'h41, 1'b1, 5'h15);
  endtask
  task automatic t_shift;
    wr(OP_SHIFT, 16'h0, 4'h1, LEN_SHORT);
    see(4'h4, 8'h41, 1'b1, 5'h00);
    wr(OP_SHIFT, 16'h0, 4'h6, LEN_SHORT);
    see(4'h6, 8'h00, 1'b1, 5'h15);
    wr(OP_SHIFT, 16'h0, 4'h0, LEN_SHORT);
    see(4'h6, 8'h00, 1'b1, 5'h15);
    // window start 3 for dots, 3 for side segments
    wr(OP_SETADDR, 16'h0300, 4'h3, LEN_LONG);
    see(4'h2, 8'h41, 1'b1, 5'h15);
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // stuck-run guard
  initial begin
    #950000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
  // main sequence
  initial begin
    {rst_n, req, key_scan_busy} = 3'h0;
    req_frame = 64'h0;
    req_bits = 7'h00;
    scan_digit = 4'h0;
    num_errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    st(5'b01000);
    t_timebase();
    t_digits();
    t_side();
    t_inc();
    t_sleep();
    t_shift();
    summarize();
  end
endmodule

// file: testbench/lcd_link_props.sv
// protocol checks on the host to decoder link wires
`timescale 1ns/100ps
module lcd_link_props
  import lcd_pkg::*;
(
  input wire logic clk,          // system clock
  input wire logic rst_n,        // async reset, active low
  input wire logic ce,           // frame enable
  input wire logic shift_strobe, // link clock
  input wire logic serial_in     // link data
);
  logic        sc_q;   // link clock last cycle
  logic        ce_q;   // enable last cycle
  logic        rise;   // link clock rising
  logic [3:0]  nadr_q; // address bits seen
  logic [7:0]  adr_q;  // address, lsb first
  logic [6:0]  ndat_q; // data bits seen
  logic [11:0] gap_q;  // cycles since frame end
  // ---------------------------------------------------------------
  // bookkeeping
  // ---------------------------------------------------------------
  assign rise = shift_strobe & ~sc_q;
  // last-cycle copies of the clock and enable wires
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sc_q <= 1'b0;
      ce_q <= 1'b0;
    end else begin
      sc_q <= shift_strobe;
      ce_q <= ce;
    end
  end
  // address byte gathered while enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nadr_q <= 4'h0;
      adr_q  <= 8'h00;
    end else if (ce) begin
      nadr_q <= 4'h0;
    end else if (rise) begin
      nadr_q <= nadr_q + 4'h1;
      adr_q  <= {serial_in, adr_q[7:1]};
    end
  end
  // data bit count, spacing since frame end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ndat_q <= 7'h00;
      gap_q  <= 12'hfff;
    end else begin
      ndat_q <= !ce ? 7'h00 : ndat_q + {6'h00, rise};
      gap_q  <= (ce_q & ~ce) ? 12'h000 : gap_q + {11'h000, gap_q != 12'hfff};
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hi;
    shift_strobe [*3] ##1 !shift_strobe;
  endsequence
  sequence s_lo;
    !shift_strobe [*4];
  endsequence
  chk_clock_high_width: assert property (rise |=> s_hi)
    else $error("link clock high time wrong");
  chk_clock_low_width: assert property ($fell(shift_strobe) |-> s_lo)
    else $error("link clock low time wrong");
  chk_data_stable: assert property (shift_strobe |-> $stable(serial_in))
    else $error("data moved while link clock high");
  chk_enable_clock_low: assert property ($changed(ce) |-> !$past(shift_strobe))
    else $error("enable moved while link clock high");
  chk_addr_count: assert property ($rose(ce) |-> nadr_q == 4'h8)
    else $error("address byte length wrong");
  chk_addr_value: assert property ($rose(ce) |-> adr_q == DEV_ADDR)
    else $error("address byte value wrong");
  chk_frame_length: assert property ($fell(ce) |-> ndat_q != 7'h00 && ndat_q <= LEN_FULL)
    else $error("frame length out of range");
  chk_idle_after_frame: assert property ($fell(ce) |-> !shift_strobe [*8])
    else $error("link clock not idle after frame");
  chk_frame_spacing: assert property (rise && !ce |-> gap_q >= EXEC_CYCLES)
    else $error("frames spaced too closely");
endmodule
